// ==== tmc_defs.svh ====
// constants for the trace main control register and its two ends
// Notes on behaviour
// [R1] bit 30 machine-tag trace, zero if unsupported
// [R2] bit 29 return stack, zero if unsupported
// [R3] software never sets bits 29 and 8
// [R4] bit 28 timestamping, zero if unsupported
// [R5] bits 27:25 select traced processor, reset zero
// [R6] select changed only under program and low-power
// [R7] select never above configured maximum
// [R8] bit 24 restricts instrumentation to privileged mode
// [R9] bit 24 zero without instrumentation resources
// [R10] bits 15:14 give context tag size
// [R11] only selected tag bytes are output
// [R12] bit 12 cycle-exact tracing, zero if unsupported
// [R13] software sets program bit around programming
// [R14] reset leaves program bit set
// [R15] halt request held until acknowledge seen
// [R16] pending halt request dropped by program bit
// [R17] bit 8 direct-branch reporting, zero if unsupported
// [R18] stall bit zero keeps nearly-full low
// [R19] stall bit one flags nearly-full buffer
// [R20] stall bit zero without nearly-full logic
// [R21] stall enable sits at bit 7
// [R22] low-power bit 0 blocks other writes, resets one; code still takes select field writes
// [R23] reserved bits read zero, ignore writes
// [R24] halt-request control sits at bit 9
`ifndef TMC_DEFS_SVH
`define TMC_DEFS_SVH
`define TMC_BIT_VMT 30
`define TMC_BIT_RSTK 29
`define TMC_BIT_TS 28
`define TMC_SEL_HI 27
`define TMC_SEL_LO 25
`define TMC_BIT_PRIV 24
`define TMC_CTX_HI 15
`define TMC_CTX_LO 14
`define TMC_BIT_CYC 12
`define TMC_BIT_PROG 10
`define TMC_BIT_HALT 9
`define TMC_BIT_DBR 8
`define TMC_BIT_STALL 7
`define TMC_BIT_LP 0
`define TMC_RESET_VAL 32'h0000_0401
`define TMC_LP_MASK 32'h0e00_0001
`define TMC_CTX_NONE 2'h0
`define TMC_CTX_ONE 2'h1
`define TMC_CTX_TWO 2'h2
`define TMC_CTX_MASK1 32'h0000_00ff
`define TMC_CTX_MASK2 32'h0000_ffff
`define TMC_CTX_MASK4 32'hffff_ffff
`endif

// ==== tmc_pkg.sv ====
// types shared by the trace main control ends
package tmc_pkg;
    typedef logic [31:0] tmc_word_t;
    typedef logic [2:0] tmc_sel_t;
    typedef enum logic [1:0] {TMC_IDLE, TMC_WRITE, TMC_READ} tmc_op_e;
endpackage

// ==== tmc_link_if.sv ====
// link between the trace control device end and the core/software end
`timescale 1ns/100ps
`default_nettype none
interface tmc_link_if;
    import tmc_pkg::*;
    logic wr_en;
    logic rd_en;
    tmc_word_t wr_data;
    tmc_word_t rd_data;
    logic trigger;
    logic buffer_almost_full;
    logic halt_request_out;
    logic halt_acknowledge_in;
    logic buffer_nearly_full;
    logic privileged;
    logic instr_access_ok;
    modport device (
        input wr_en, rd_en, wr_data, trigger, buffer_almost_full, halt_acknowledge_in,
        input privileged,
        output rd_data, halt_request_out, buffer_nearly_full, instr_access_ok
    );
    modport host (
        output wr_en, rd_en, wr_data, trigger, buffer_almost_full, halt_acknowledge_in,
        output privileged,
        input rd_data, halt_request_out, buffer_nearly_full, instr_access_ok
    );
endinterface
`default_nettype wire

// ==== tmc_ctx_mask.sv ====
// masks a context tag down to the selected number of bytes
`timescale 1ns/100ps
`include "tmc_defs.svh"
`default_nettype none
module tmc_ctx_mask
    import tmc_pkg::*;
(
    input wire logic [1:0] size,
    input wire tmc_word_t tag_in,
    output logic tag_valid,
    output tmc_word_t tag_out
);
    tmc_word_t mask;
    always_comb begin
        case (size)
            `TMC_CTX_NONE: mask = '0; // R10
            `TMC_CTX_ONE: mask = `TMC_CTX_MASK1; // R10
            `TMC_CTX_TWO: mask = `TMC_CTX_MASK2; // R10
            default: mask = `TMC_CTX_MASK4; // R10
        endcase
    end
    assign tag_valid = (size != `TMC_CTX_NONE);
    assign tag_out = tag_in & mask; // R11
endmodule // tmc_ctx_mask
`default_nettype wire

// ==== tmc_device.sv ====
// device end: main control register, halt request and stall output
`timescale 1ns/100ps
`include "tmc_defs.svh"
`default_nettype none
module tmc_device
    import tmc_pkg::*;
#(
    parameter logic HAS_VMT = 1'b1,
    parameter logic HAS_RSTK = 1'b1,
    parameter logic HAS_TS = 1'b1,
    parameter logic [2:0] INSTR_COUNT = 3'h1,
    parameter logic HAS_CTX = 1'b1,
    parameter logic HAS_CYC = 1'b1,
    parameter logic HAS_DBR = 1'b1,
    parameter logic HAS_STALL = 1'b1
) (
    input wire logic CORE_CLK,
    input wire logic RST_B,
    input wire logic CLK_EN,
    tmc_link_if.device LINK,
    input wire tmc_word_t CONTEXT_TAG,
    output logic CONTEXT_TAG_VALID,
    output tmc_word_t CONTEXT_TAG_OUT,
    output tmc_sel_t PROC_SELECT,
    output logic LOW_POWER_HOLD,
    output logic CONFIG_PROGRAM_BIT,
    output logic VMT_ENABLE,
    output logic RSTK_ENABLE,
    output logic TS_ENABLE,
    output logic CYCLE_EXACT_ENABLE,
    output logic DIRECT_BRANCH_REPORT
);
    tmc_word_t main_control_reg;
    tmc_word_t main_control_next;
    tmc_word_t wr_mask;
    logic halt_req_reg;
    logic nf_reg;

    // implemented writable bits; absent features stay zero on read and write
    function automatic tmc_word_t impl_mask();
        tmc_word_t m;
        m = '0;
        m[`TMC_BIT_VMT] = HAS_VMT; // R1
        m[`TMC_BIT_RSTK] = HAS_RSTK; // R2
        m[`TMC_BIT_TS] = HAS_TS; // R4
        m[`TMC_SEL_HI:`TMC_SEL_LO] = 3'h7; // R5
        m[`TMC_BIT_PRIV] = (INSTR_COUNT != 3'h0); // R9
        m[`TMC_CTX_HI:`TMC_CTX_LO] = {2{HAS_CTX}}; // R11
        m[`TMC_BIT_CYC] = HAS_CYC; // R12
        m[`TMC_BIT_PROG] = 1'b1;
        m[`TMC_BIT_HALT] = 1'b1; // R24
        m[`TMC_BIT_DBR] = HAS_DBR; // R17
        m[`TMC_BIT_STALL] = HAS_STALL; // R20 R21
        m[`TMC_BIT_LP] = 1'b1;
        return m; // R23
    endfunction

    always_comb begin
        // while low power is set only bit 0 and the select field take writes
        if (main_control_reg[`TMC_BIT_LP]) begin
            wr_mask = impl_mask() & `TMC_LP_MASK; // R22
        end else begin
            wr_mask = impl_mask();
        end
        main_control_next = (main_control_reg & ~wr_mask) | (LINK.wr_data & wr_mask);
    end

    always_ff @(posedge CORE_CLK or negedge RST_B) begin
        if (!RST_B) begin
            main_control_reg <= `TMC_RESET_VAL; // R14 R22
        end else if (CLK_EN && LINK.wr_en) begin
            main_control_reg <= main_control_next;
        end
    end

    // pending request is dropped when the program bit is set: a reprogrammed
    // unit should not halt the core on a stale trigger
    always_ff @(posedge CORE_CLK or negedge RST_B) begin
        if (!RST_B) begin
            halt_req_reg <= 1'b0;
        end else if (CLK_EN) begin
            if (LINK.halt_acknowledge_in || main_control_reg[`TMC_BIT_PROG]) begin
                halt_req_reg <= 1'b0; // R15 R16
            end else if (LINK.trigger && main_control_reg[`TMC_BIT_HALT]) begin
                halt_req_reg <= 1'b1; // R15
            end
        end
    end

    always_ff @(posedge CORE_CLK or negedge RST_B) begin
        if (!RST_B) begin
            nf_reg <= 1'b0;
        end else if (CLK_EN) begin
            nf_reg <= main_control_reg[`TMC_BIT_STALL] && LINK.buffer_almost_full; // R18 R19
        end
    end

    tmc_ctx_mask u_ctx (
        .size(main_control_reg[`TMC_CTX_HI:`TMC_CTX_LO]),
        .tag_in(CONTEXT_TAG),
        .tag_valid(CONTEXT_TAG_VALID),
        .tag_out(CONTEXT_TAG_OUT)
    );

    assign LINK.rd_data = main_control_reg;
    assign LINK.halt_request_out = halt_req_reg;
    assign LINK.buffer_nearly_full = nf_reg;
    assign LINK.instr_access_ok = !main_control_reg[`TMC_BIT_PRIV] || LINK.privileged; // R8
    assign PROC_SELECT = main_control_reg[`TMC_SEL_HI:`TMC_SEL_LO]; // R5
    assign LOW_POWER_HOLD = main_control_reg[`TMC_BIT_LP];
    assign CONFIG_PROGRAM_BIT = main_control_reg[`TMC_BIT_PROG];
    assign VMT_ENABLE = main_control_reg[`TMC_BIT_VMT];
    assign RSTK_ENABLE = main_control_reg[`TMC_BIT_RSTK];
    assign TS_ENABLE = main_control_reg[`TMC_BIT_TS];
    assign CYCLE_EXACT_ENABLE = main_control_reg[`TMC_BIT_CYC];
    assign DIRECT_BRANCH_REPORT = main_control_reg[`TMC_BIT_DBR];
endmodule // tmc_device
`default_nettype wire

// ==== tmc_host.sv ====
// host end: software writes/reads and core-side halt and stall signals
`timescale 1ns/100ps
`include "tmc_defs.svh"
`default_nettype none
module tmc_host
    import tmc_pkg::*;
(
    input wire logic CORE_CLK,
    input wire logic RST_B,
    input wire logic CLK_EN,
    tmc_link_if.host LINK,
    input wire logic CMD_VALID,
    input wire logic CMD_WRITE,
    input wire tmc_word_t CMD_DATA,
    input wire tmc_sel_t MAX_SELECT,
    input wire logic TRIGGER,
    input wire logic ALMOST_FULL,
    input wire logic CORE_PRIVILEGED,
    output logic CMD_READY,
    output logic CMD_ERROR,
    output tmc_word_t READ_DATA,
    output logic CORE_HALTED,
    output logic CORE_STALL
);
    tmc_op_e op_reg;
    tmc_word_t wdata_reg;
    logic err_reg;
    tmc_word_t rdata_reg;
    logic halted_reg;
    logic cmd_ok;

    // refuse select above maximum and return stack with direct-branch report
    assign cmd_ok = (CMD_DATA[`TMC_SEL_HI:`TMC_SEL_LO] <= MAX_SELECT) && // R7
        !(CMD_DATA[`TMC_BIT_RSTK] && CMD_DATA[`TMC_BIT_DBR]); // R3
    assign CMD_READY = (op_reg == TMC_IDLE);

    always_ff @(posedge CORE_CLK or negedge RST_B) begin
        if (!RST_B) begin
            op_reg <= TMC_IDLE;
            wdata_reg <= '0;
            err_reg <= 1'b0;
        end else if (CLK_EN) begin
            case (op_reg)
                TMC_IDLE: begin
                    if (CMD_VALID && CMD_WRITE) begin
                        err_reg <= !cmd_ok;
                        wdata_reg <= CMD_DATA;
                        op_reg <= cmd_ok ? TMC_WRITE : TMC_IDLE;
                    end else if (CMD_VALID) begin
                        err_reg <= 1'b0;
                        op_reg <= TMC_READ;
                    end
                end
                default: op_reg <= TMC_IDLE;
            endcase
        end
    end

    always_ff @(posedge CORE_CLK or negedge RST_B) begin
        if (!RST_B) begin
            rdata_reg <= '0;
        end else if (CLK_EN && op_reg == TMC_READ) begin
            rdata_reg <= LINK.rd_data;
        end
    end

    // the core halts one cycle after the request and acknowledges while halted
    always_ff @(posedge CORE_CLK or negedge RST_B) begin
        if (!RST_B) begin
            halted_reg <= 1'b0;
        end else if (CLK_EN) begin
            halted_reg <= LINK.halt_request_out; // R15
        end
    end

    // R6 and R13 are sequences software issues through the command port
    assign LINK.wr_en = CLK_EN && (op_reg == TMC_WRITE);
    assign LINK.rd_en = (op_reg == TMC_READ);
    assign LINK.wr_data = wdata_reg;
    assign LINK.trigger = TRIGGER;
    assign LINK.buffer_almost_full = ALMOST_FULL;
    assign LINK.halt_acknowledge_in = halted_reg;
    assign LINK.privileged = CORE_PRIVILEGED;
    assign CMD_ERROR = err_reg;
    assign READ_DATA = rdata_reg;
    assign CORE_HALTED = halted_reg;
    assign CORE_STALL = LINK.buffer_nearly_full;
endmodule // tmc_host
`default_nettype wire

// ==== tmc_link_chk.sv ====
// concurrent checks on the link between the two control ends
`timescale 1ns/100ps
`include "tmc_defs.svh"
`default_nettype none
module tmc_link_chk
    import tmc_pkg::*;
(
    input wire logic CORE_CLK,
    input wire logic RST_B,
    input wire logic wr_en,
    input wire logic rd_en,
    input wire tmc_word_t wr_data,
    input wire tmc_word_t rd_data,
    input wire logic trigger,
    input wire logic buffer_almost_full,
    input wire logic halt_request_out,
    input wire logic halt_acknowledge_in,
    input wire logic buffer_nearly_full,
    input wire logic privileged,
    input wire logic instr_access_ok
);
    default clocking @(posedge CORE_CLK); endclocking
    default disable iff (!RST_B);
    chk_stall_quiet: assert property (!rd_data[7] |=> !buffer_nearly_full)
        else $error("nearly full raised with stall off");
    chk_stall_flag: assert property (rd_data[7] && buffer_almost_full |=> buffer_nearly_full)
        else $error("nearly full missing");
    chk_halt_raise: assert property (trigger && rd_data[9] && !rd_data[10] && !halt_acknowledge_in
        |=> halt_request_out)
        else $error("halt request not raised");
    chk_halt_hold: assert property (halt_request_out && !halt_acknowledge_in && !rd_data[10]
        |=> halt_request_out)
        else $error("halt request dropped early");
    chk_halt_drop: assert property (halt_acknowledge_in || rd_data[10] |=> !halt_request_out)
        else $error("halt request kept");
    chk_halt_cause: assert property ($rose(halt_request_out) |-> $past(trigger && rd_data[9]))
        else $error("halt request without trigger");
    // low power keeps everything but the select and bit 0
    chk_lp_freeze: assert property (wr_en && rd_data[0] |=>
        (rd_data & ~`TMC_LP_MASK) == ($past(rd_data) & ~`TMC_LP_MASK))
        else $error("write landed under low power");
    chk_write_take: assert property (wr_en && !rd_data[0] |=>
        rd_data == ($past(wr_data) & 32'h7f00_d781))
        else $error("written value not held");
    chk_resv_zero: assert property ((rd_data & 32'h80ff_287e) == 32'h0)
        else $error("reserved bit set");
    chk_access_ok: assert property (instr_access_ok == (!rd_data[24] || privileged))
        else $error("instrumentation access wrong");
    cover property ($rose(halt_request_out));
    cover property (buffer_nearly_full);
    cover property (wr_en && rd_data[0]);
    cover property (rd_en);
endmodule // tmc_link_chk
`default_nettype wire

// ==== tb_top.sv ====
// self-checking bench joining the device and host control ends
`timescale 1ns/100ps
`default_nettype none
module tb_top import tmc_pkg::*;;
    typedef struct {tmc_word_t wr; tmc_word_t rd; tmc_word_t tag;} tmc_row_s;
    logic core_clk = 1'b0;
    logic rst_b = 1'b0;
    logic cmd_valid = 1'b0;
    logic cmd_write = 1'b0;
    tmc_word_t cmd_data = 32'h0;
    tmc_sel_t max_select = 3'h7;
    logic trigger = 1'b0;
    logic almost_full = 1'b0;
    logic core_priv = 1'b0;
    logic clk_en = 1'b1;
    logic cmd_ready, cmd_error, core_halted, core_stall;
    tmc_word_t read_data, tag_out;
    int mismatches = 0;
    int compares = 0;
    tmc_row_s rows [5] = '{
        '{32'h7e00_0401, 32'h0e00_0401, 32'h0},
        '{32'h0000_0400, 32'h0000_0400, 32'h0},
        '{32'hf1ff_fefe, 32'h7100_d680, 32'ha5c3_9e17},
        '{32'h0000_4700, 32'h0000_4700, 32'h17},
        '{32'h0000_8400, 32'h0000_8400, 32'h9e17}};
    tmc_link_if tmc_link_if_i();
    tmc_device tmc_device_i (.CORE_CLK(core_clk), .RST_B(rst_b), .CLK_EN(clk_en),
        .LINK(tmc_link_if_i.device), .CONTEXT_TAG(32'ha5c3_9e17),
        .CONTEXT_TAG_VALID(), .CONTEXT_TAG_OUT(tag_out), .PROC_SELECT(),
        .LOW_POWER_HOLD(), .CONFIG_PROGRAM_BIT(), .VMT_ENABLE(), .RSTK_ENABLE(),
        .TS_ENABLE(), .CYCLE_EXACT_ENABLE(), .DIRECT_BRANCH_REPORT());
    tmc_host tmc_host_i (.CORE_CLK(core_clk), .RST_B(rst_b), .CLK_EN(clk_en),
        .LINK(tmc_link_if_i.host), .CMD_VALID(cmd_valid), .CMD_WRITE(cmd_write),
        .CMD_DATA(cmd_data), .MAX_SELECT(max_select), .TRIGGER(trigger),
        .ALMOST_FULL(almost_full), .CORE_PRIVILEGED(core_priv), .CMD_READY(cmd_ready),
        .CMD_ERROR(cmd_error), .READ_DATA(read_data), .CORE_HALTED(core_halted),
        .CORE_STALL(core_stall));
    tmc_link_chk tmc_link_chk_i (.CORE_CLK(core_clk), .RST_B(rst_b),
        .wr_en(tmc_link_if_i.wr_en), .rd_en(tmc_link_if_i.rd_en),
        .wr_data(tmc_link_if_i.wr_data), .rd_data(tmc_link_if_i.rd_data),
        .trigger(tmc_link_if_i.trigger),
        .buffer_almost_full(tmc_link_if_i.buffer_almost_full),
        .halt_request_out(tmc_link_if_i.halt_request_out),
        .halt_acknowledge_in(tmc_link_if_i.halt_acknowledge_in),
        .buffer_nearly_full(tmc_link_if_i.buffer_nearly_full),
        .privileged(tmc_link_if_i.privileged),
        .instr_access_ok(tmc_link_if_i.instr_access_ok));
    initial forever #5 core_clk = ~core_clk;
    task automatic chk(input tmc_word_t seen, input tmc_word_t exp);
        compares++;
        if (seen !== exp) begin
            mismatches++;
            $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask
    task automatic report_and_stop;
        if (mismatches == 0 && compares > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    // entered at a falling edge; leaves two cycles later so requests keep their spacing
    task automatic cmd(input logic w, input tmc_word_t d);
        int n;
        n = 0;
        cmd_valid = 1'b1;
        cmd_write = w;
        cmd_data = d;
        // ready is looked at between edges, where it has settled
        while (cmd_ready !== 1'b1 && n < 20) begin
            n++;
            @(negedge core_clk);
        end
        if (n >= 20) mismatches++;
        @(posedge core_clk);
        @(negedge core_clk);
        cmd_valid = 1'b0;
        @(negedge core_clk);
    endtask
    // returns one cycle after the trigger, while a raised halt still stands
    task automatic pulse_trigger;
        trigger = 1'b1;
        @(negedge core_clk);
        trigger = 1'b0;
        @(negedge core_clk);
    endtask
    initial begin
        repeat (12) @(negedge core_clk);
        rst_b = 1'b1;
        cmd(1'b0, 32'h0);
        chk(read_data, 32'h0000_0401);
        for (int i = 0; i < 5; i++) begin
            cmd(1'b1, rows[i].wr);
            cmd(1'b0, 32'h0);
            chk(read_data, rows[i].rd);
            chk(tag_out, rows[i].tag);
        end
        max_select = 3'h2;
        cmd(1'b1, 32'h0600_8400);
        chk({31'h0, cmd_error}, 32'h1);
        cmd(1'b1, 32'h2000_8500);
        chk({31'h0, cmd_error}, 32'h1);
        cmd(1'b0, 32'h0);
        chk(read_data, 32'h0000_8400);
        cmd(1'b1, 32'h0000_0600);
        pulse_trigger();
        chk({31'h0, core_halted}, 32'h0);
        core_priv = 1'b1;
        cmd(1'b1, 32'h0000_0200);
        pulse_trigger();
        chk({31'h0, core_halted}, 32'h1);
        @(negedge core_clk);
        chk({31'h0, core_halted}, 32'h1);
        repeat (2) @(negedge core_clk);
        chk({31'h0, core_halted}, 32'h0);
        almost_full = 1'b1;
        repeat (3) @(negedge core_clk);
        chk({31'h0, core_stall}, 32'h0);
        cmd(1'b1, 32'h0000_0080);
        repeat (2) @(negedge core_clk);
        chk({31'h0, core_stall}, 32'h1);
        clk_en = 1'b0;
        almost_full = 1'b0;
        repeat (2) @(negedge core_clk);
        chk({31'h0, core_stall}, 32'h1);
        clk_en = 1'b1;
        repeat (2) @(negedge core_clk);
        chk({31'h0, core_stall}, 32'h0);
        rst_b = 1'b0;
        repeat (2) @(negedge core_clk);
        rst_b = 1'b1;
        cmd(1'b0, 32'h0);
        chk(read_data, 32'h0000_0401);
        report_and_stop();
    end
    // the whole sequence needs well under 200 cycles
    initial begin
        repeat (2000) @(posedge core_clk);
        mismatches++;
        report_and_stop();
    end
endmodule // tb_top
`default_nettype wire
